// ===== pkg/dsrcs_pkg.sv
// constants and types shared by the dual SAR range/channel control block
// Summary of operation
// (RULE1) CS fall captures span-select level for next conversion
// (RULE2) low at CS fall: unit span, straight binary
// (RULE3) high at CS fall: double span, twos complement
// (RULE4) level change at edge eight flips coding only
// (RULE5) four level pairs map to span and coding
// (RULE6) CS fall captures channel-pair select for both muxes
// (RULE7) pair select low: channel one; high: channel two
// (RULE8) code steps at integer LSB, LSB is reference/4096
// (RULE9) track during acquisition, hold when conversion starts
// (RULE10) trial bits adjusted until rebalanced, then deliver code
// (RULE11) serial clock shifts data and steps conversion
// (RULE12) host lowers CS; device samples and starts there
// (RULE13) host gives sixteen serial clocks per conversion
// (RULE14) twos complement is straight binary with MSB inverted
package dsrcs_pkg;
   localparam int          CODE_W          = 12;
   localparam int          NUM_CONV        = 2;
   localparam int          CNT_W           = 5;
   localparam int          IDX_W           = 4;
   // 4096 codes per span: one LSB is the reference over 2**CODE_W
   localparam logic [CODE_W-1:0] TRIAL_FIRST = 12'h800;
   localparam logic [CODE_W-1:0] MSB_FLIP    = 12'h800;
   localparam logic [IDX_W-1:0]  IDX_MSB     = 4'hB;
   localparam logic [IDX_W-1:0]  IDX_LSB     = 4'h0;
   localparam logic [CNT_W-1:0]  EDGE_CODING  = 5'h08;
   localparam logic [CNT_W-1:0]  EDGE_STEP_LO = 5'h04;
   localparam logic [CNT_W-1:0]  EDGE_STEP_HI = 5'h0F;
   localparam logic [CNT_W-1:0]  EDGE_LAST    = 5'h10;
   localparam logic [CNT_W-1:0]  EDGE_RESET   = 5'h00;
   localparam logic [CODE_W-1:0] CODE_RESET   = 12'h000;

   typedef enum logic [0:0] {ST_IDLE, ST_CONV} dsrcs_state_type;
   typedef logic [NUM_CONV-1:0][CODE_W-1:0] dsrcs_codes_type;
endpackage : dsrcs_pkg

// ===== pkg/dsrcs_sar_if.sv
// carrier between the frame controller and the dual SAR engine
`timescale 1ns/100ps
interface dsrcs_sar_if;
   import dsrcs_pkg::*;
   logic                  start;
   logic                  abort;
   logic                  step;
   logic [NUM_CONV-1:0]   comp;
   logic                  done;
   dsrcs_codes_type       trial;

   modport ctrl (output start, output abort, output step, output comp, input done, input trial);
   modport sar  (input start, input abort, input step, input comp, output done, output trial);
endinterface : dsrcs_sar_if

// ===== src/dsrcs_sar.sv
// dual successive-approximation register, one trial word per converter
`timescale 1ns/100ps
module dsrcs_sar
(
   input  wire logic  clk,
   input  wire logic  rst,
   dsrcs_sar_if.sar   sif
);
   import dsrcs_pkg::*;

   typedef struct packed {
      dsrcs_codes_type  trial;
      logic [IDX_W-1:0] idx;
      logic             busy;
      logic             done;
   } dsrcs_sar_type;

   dsrcs_sar_type s_r;
   dsrcs_sar_type s_nxt;

   assign sif.trial = s_r.trial;
   assign sif.done  = s_r.done;

   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (sif.abort)
      begin
         s_nxt.busy = 1'b0;
      end
      else if (sif.start)
      begin
         s_nxt.busy = 1'b1;
         s_nxt.idx  = IDX_MSB;
         for (int i = 0; i < NUM_CONV; i++)
         begin
            s_nxt.trial[i] = TRIAL_FIRST; // RULE9
         end
      end
      else if (sif.step && s_r.busy)
      begin
         for (int i = 0; i < NUM_CONV; i++)
         begin
            // comparator low means the trial overshoots the held sample
            if (!sif.comp[i])
            begin
               s_nxt.trial[i][s_r.idx] = 1'b0; // RULE10
            end
            if (s_r.idx != IDX_LSB)
            begin
               s_nxt.trial[i][s_r.idx - 4'h1] = 1'b1; // RULE8
            end
         end
         if (s_r.idx == IDX_LSB)
         begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1; // RULE10
         end
         else
         begin
            s_nxt.idx = s_r.idx - 4'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
endmodule : dsrcs_sar

// ===== src/dsrcs_top.sv
// frame controller: chip-select/serial-clock sequencing, span and coding selection, serial data
`timescale 1ns/100ps
module dsrcs_top
(
   input  wire logic                         CLK_SYS,
   input  wire logic                         RST,
   input  wire logic                         CS_N,
   input  wire logic                         SCLK,
   input  wire logic                         RANGE_SEL,
   input  wire logic                         CHANNEL_PAIR_SELECT,
   input  wire logic [dsrcs_pkg::NUM_CONV-1:0] COMP,
   output logic                              TRACK,
   output logic                              MUX_CH2,
   output logic                              SPAN_DOUBLE,
   output logic                              CODING_TWOS,
   output logic [dsrcs_pkg::CODE_W-1:0]      DAC_A,
   output logic [dsrcs_pkg::CODE_W-1:0]      DAC_B,
   output logic [dsrcs_pkg::CODE_W-1:0]      RESULT_A,
   output logic [dsrcs_pkg::CODE_W-1:0]      RESULT_B,
   output logic                              RESULT_VALID,
   output logic                              DOUT_A,
   output logic                              DOUT_B,
   output logic                              DOUT_OE_N
);
   import dsrcs_pkg::*;

   typedef struct packed {
      logic [1:0]             cs_s;
      logic [1:0]             sclk_s;
      logic [1:0]             rng_s;
      logic [1:0]             cps_s;
      logic [1:0][NUM_CONV-1:0] cmp_s;
      logic                   cs_d;
      logic                   sclk_d;
      dsrcs_state_type        state;
      logic [CNT_W-1:0]       edge_cnt;
      logic                   track;
      logic                   mux_ch2;
      logic                   span_double;
      logic                   twos;
      logic [NUM_CONV-1:0]    dout;
      logic                   oe_n;
      dsrcs_codes_type        result;
      logic                   valid;
      logic                   start;
      logic                   abort;
      logic                   step;
   } dsrcs_ctl_type;

   dsrcs_ctl_type s_r;
   dsrcs_ctl_type s_nxt;
   dsrcs_sar_if   sif ();

   // true on the sample where a synchronised level has just gone low
   function automatic logic fell(input logic prev, input logic cur);
      fell = prev & ~cur;
   endfunction : fell

   dsrcs_sar u_sar
   (
      .clk (CLK_SYS),
      .rst (RST),
      .sif (sif.sar)
   );

   assign sif.start = s_r.start;
   assign sif.abort = s_r.abort;
   assign sif.step  = s_r.step;
   assign sif.comp  = s_r.cmp_s[1];

   assign TRACK        = s_r.track;
   assign MUX_CH2      = s_r.mux_ch2;
   assign SPAN_DOUBLE  = s_r.span_double;
   assign CODING_TWOS  = s_r.twos;
   assign DAC_A        = sif.trial[0];
   assign DAC_B        = sif.trial[1];
   assign RESULT_A     = s_r.result[0];
   assign RESULT_B     = s_r.result[1];
   assign RESULT_VALID = s_r.valid;
   assign DOUT_A       = s_r.dout[0];
   assign DOUT_B       = s_r.dout[1];
   assign DOUT_OE_N    = s_r.oe_n;

   always_comb
   begin
      logic [CNT_W-1:0] e;
      e           = EDGE_RESET;
      s_nxt       = s_r;
      s_nxt.cs_s   = {s_r.cs_s[0], CS_N};
      s_nxt.sclk_s = {s_r.sclk_s[0], SCLK};
      s_nxt.rng_s  = {s_r.rng_s[0], RANGE_SEL};
      s_nxt.cps_s  = {s_r.cps_s[0], CHANNEL_PAIR_SELECT};
      s_nxt.cmp_s  = {s_r.cmp_s[0], COMP};
      s_nxt.cs_d   = s_r.cs_s[1];
      s_nxt.sclk_d = s_r.sclk_s[1];
      s_nxt.start  = 1'b0;
      s_nxt.abort  = 1'b0;
      s_nxt.step   = 1'b0;
      s_nxt.valid  = 1'b0;
      case (s_r.state)
         ST_IDLE:
         begin
            if (fell(s_r.cs_d, s_r.cs_s[1])) // RULE12
            begin
               s_nxt.span_double = s_r.rng_s[1]; // RULE1
               s_nxt.twos        = s_r.rng_s[1]; // RULE2 RULE3
               s_nxt.mux_ch2     = s_r.cps_s[1]; // RULE6 RULE7
               s_nxt.track       = 1'b0;         // RULE9
               s_nxt.start       = 1'b1;
               s_nxt.edge_cnt    = EDGE_RESET;
               s_nxt.dout        = '0;
               s_nxt.oe_n        = 1'b0;
               s_nxt.state       = ST_CONV;
            end
         end
         ST_CONV:
         begin
            if (fell(s_r.cs_s[1], s_r.cs_d))
            begin
               // chip select raised: any unfinished conversion is dropped
               s_nxt.abort = 1'b1;
               s_nxt.track = 1'b1;
               s_nxt.oe_n  = 1'b1;
               s_nxt.dout  = '0;
               s_nxt.state = ST_IDLE;
            end
            else if (fell(s_r.sclk_d, s_r.sclk_s[1]) && s_r.edge_cnt != EDGE_LAST) // RULE13
            begin
               e              = s_r.edge_cnt + 5'h01;
               s_nxt.edge_cnt = e;
               if (e == EDGE_CODING)
               begin
                  // span stays; only coding follows the level at this edge
                  s_nxt.twos = s_r.rng_s[1]; // RULE4 RULE5
               end
               if (e >= EDGE_STEP_LO && e <= EDGE_STEP_HI)
               begin
                  s_nxt.step = 1'b1; // RULE11
                  // serial bit is the decision made on this edge; the MSB uses the coding known now
                  s_nxt.dout = s_r.cmp_s[1] ^ ((e == EDGE_STEP_LO) ? {NUM_CONV{s_r.twos}} : '0); // RULE11
               end
               else
               begin
                  s_nxt.dout = '0;
               end
               if (e == EDGE_LAST)
               begin
                  s_nxt.track = 1'b1; // RULE9
               end
            end
            if (sif.done)
            begin
               for (int i = 0; i < NUM_CONV; i++)
               begin
                  s_nxt.result[i] = sif.trial[i] ^ (s_r.twos ? MSB_FLIP : CODE_RESET); // RULE14
               end
               s_nxt.valid = 1'b1; // RULE10
            end
         end
         default:
         begin
            s_nxt.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         s_r        <= '0;
         s_r.cs_s   <= 2'b11;
         s_r.cs_d   <= 1'b1;
         s_r.sclk_s <= 2'b11;
         s_r.sclk_d <= 1'b1;
         s_r.state  <= ST_IDLE;
         s_r.track  <= 1'b1;
         s_r.oe_n   <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
endmodule : dsrcs_top

// ===== bench/dsrcs_properties.sv
// port-level checks of the range/channel control block
`timescale 1ns/100ps
module dsrcs_properties
(
   input wire logic                         CLK_SYS,
   input wire logic                         RST,
   input wire logic                         TRACK,
   input wire logic                         MUX_CH2,
   input wire logic                         SPAN_DOUBLE,
   input wire logic                         CODING_TWOS,
   input wire logic [dsrcs_pkg::CODE_W-1:0] DAC_A,
   input wire logic [dsrcs_pkg::CODE_W-1:0] DAC_B,
   input wire logic [dsrcs_pkg::CODE_W-1:0] RESULT_A,
   input wire logic                         RESULT_VALID,
   input wire logic                         DOUT_A,
   input wire logic                         DOUT_B,
   input wire logic                         DOUT_OE_N
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   AST_SPAN_AT_START: assert property ($changed(SPAN_DOUBLE) |-> $fell(TRACK))
      else $error("span changed outside a frame start");
   AST_MUX_AT_START: assert property ($changed(MUX_CH2) |-> $fell(TRACK))
      else $error("channel pair changed outside a frame start");
   AST_CODING_IN_FRAME: assert property ($changed(CODING_TWOS) |-> !TRACK)
      else $error("coding changed outside a conversion");
   AST_FIRST_TRIAL: assert property ($fell(TRACK) |=> DAC_A == 12'h800 && DAC_B == 12'h800)
      else $error("first trial word wrong");
   AST_RESULT_CODING: assert property (RESULT_VALID |-> RESULT_A == (DAC_A ^ {CODING_TWOS, 11'h000}))
      else $error("result coding wrong");
   AST_VALID_PULSE: assert property (RESULT_VALID |=> !RESULT_VALID)
      else $error("result valid longer than one cycle");
   AST_RESULT_HOLDS: assert property ($changed(RESULT_A) |-> RESULT_VALID)
      else $error("result changed without valid");
   AST_HOLD_IN_CONV: assert property (RESULT_VALID |-> !TRACK)
      else $error("result delivered while tracking");
   AST_DRIVE_AT_START: assert property ($fell(TRACK) |-> !DOUT_OE_N)
      else $error("output not enabled at frame start");
   AST_IDLE_ZERO: assert property (DOUT_OE_N |-> !DOUT_A && !DOUT_B)
      else $error("serial data not zero while disabled");
   cover property (RESULT_VALID && CODING_TWOS && !SPAN_DOUBLE);
   cover property (RESULT_VALID && SPAN_DOUBLE && !CODING_TWOS);
   cover property ($rose(TRACK) && !RESULT_VALID);
   cover property (RESULT_VALID && MUX_CH2);
endmodule : dsrcs_properties

bind dsrcs_top dsrcs_properties u_props (.CLK_SYS(CLK_SYS), .RST(RST), .TRACK(TRACK), .MUX_CH2(MUX_CH2),
   .SPAN_DOUBLE(SPAN_DOUBLE), .CODING_TWOS(CODING_TWOS), .DAC_A(DAC_A), .DAC_B(DAC_B), .RESULT_A(RESULT_A),
   .RESULT_VALID(RESULT_VALID), .DOUT_A(DOUT_A), .DOUT_B(DOUT_B), .DOUT_OE_N(DOUT_OE_N));

// ===== bench/dsrcs_host_model.sv
// host serial port model: chip select, serial clock, select pins, data capture
`timescale 1ns/100ps
module dsrcs_host_model
(
   output logic        cs_n,
   output logic        sclk,
   output logic        range_sel,
   output logic        pair_sel,
   input  wire logic   dout,
   input  wire logic   dout_b,
   output logic [15:0] rx,
   output logic [15:0] rx_b
);
   initial
   begin
      cs_n = 1'h1;
      sclk = 1'h1;
      range_sel = 1'h0;
      pair_sel = 1'h0;
   end

   // sampled on the rising edge, half a period after the device launched the bit
   always @(posedge sclk)
      if (!cs_n)
         rx <= {rx[14:0], dout};

   // second data line is read in parallel, so both converters are checked bit by bit
   always @(posedge sclk)
      if (!cs_n)
         rx_b <= {rx_b[14:0], dout_b};

   // serial clock stands high between frames
   task frame(input logic lvl_a, input logic lvl_b, input logic pair, input int edges);
      range_sel = lvl_a;
      pair_sel = pair;
      rx = 16'h0000;
      rx_b = 16'h0000;
      #100 cs_n = 1'h0;
      #100;
      for (int k = 1; k <= edges; k++)
      begin
         if (k == 8)
            range_sel = lvl_b;
         #62.5 sclk = 1'h0;
         #62.5 sclk = 1'h1;
      end
      #100 cs_n = 1'h1;
      #100;
   endtask : frame
endmodule : dsrcs_host_model

// ===== bench/testbench.sv
// self-checking bench of the range/channel control block
`timescale 1ns/100ps
module testbench;
   import dsrcs_pkg::*;
   logic              clk_sys, rst, cs_n, sclk, range_sel, pair_sel;
   logic              track, mux_ch2, span_double, coding_twos, result_valid, dout_a, dout_b, dout_oe_n;
   logic [CODE_W-1:0] dac_a, dac_b, result_a, result_b, vin_a, vin_b;
   logic [1:0]        comp;
   logic [15:0]       rx, rx_b;
   int                n_errors = 0;
   int                checks_done = 0;
   int                n_valid = 0;

   // ideal comparators: held input against trial word
   assign comp = {vin_b >= dac_b, vin_a >= dac_a};

   dsrcs_top u_dut (.CLK_SYS(clk_sys), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .RANGE_SEL(range_sel),
      .CHANNEL_PAIR_SELECT(pair_sel), .COMP(comp), .TRACK(track), .MUX_CH2(mux_ch2), .SPAN_DOUBLE(span_double),
      .CODING_TWOS(coding_twos), .DAC_A(dac_a), .DAC_B(dac_b), .RESULT_A(result_a), .RESULT_B(result_b),
      .RESULT_VALID(result_valid), .DOUT_A(dout_a), .DOUT_B(dout_b), .DOUT_OE_N(dout_oe_n));
   dsrcs_host_model u_host (.cs_n(cs_n), .sclk(sclk), .range_sel(range_sel), .pair_sel(pair_sel),
      .dout(dout_a), .dout_b(dout_b), .rx(rx), .rx_b(rx_b));

   initial
   begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      if (result_valid === 1'h1)
         n_valid <= n_valid + 1;

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task convert_and_check(input logic a, input logic b, input logic p, input logic [11:0] va, input logic [11:0] vb);
      int nv;
      nv = n_valid;
      vin_a = va;
      vin_b = vb;
      u_host.frame(a, b, p, 16);
      chk(16'(span_double), 16'(a));
      chk(16'(coding_twos), 16'(b));
      chk(16'(mux_ch2), 16'(p));
      chk(16'(result_a), 16'(va ^ {b, 11'h000}));
      chk(16'(result_b), 16'(vb ^ {b, 11'h000}));
      chk(16'(n_valid - nv), 16'h0001);
      chk(16'(track), 16'h0001);
      chk(rx, {3'h0, va ^ {a, 11'h000}, 1'h0});
      chk(rx_b, {3'h0, vb ^ {a, 11'h000}, 1'h0});
   endtask : convert_and_check

   task sc_coding_table();
      logic [11:0] va_tab [4];
      va_tab = '{12'hA5C, 12'hFFF, 12'h000, 12'h801};
      for (int i = 0; i < 4; i++)
         convert_and_check(i[1], i[0], 1'h0, va_tab[i], ~va_tab[i]);
   endtask : sc_coding_table

   // conversion cut short after edge eight must leave no result and release the line
   task sc_abort();
      int nv;
      logic [11:0] held;
      nv = n_valid;
      held = result_a;
      vin_a = 12'h123;
      u_host.frame(1'h1, 1'h1, 1'h1, 8);
      chk(16'(n_valid - nv), 16'h0000);
      chk(16'(result_a), 16'(held));
      chk(16'(track), 16'h0001);
      chk(16'(dout_oe_n), 16'h0001);
   endtask : sc_abort

   task sc_channel_pair();
      convert_and_check(1'h0, 1'h0, 1'h1, 12'h7FF, 12'h800);
      convert_and_check(1'h1, 1'h0, 1'h0, 12'h001, 12'hFFE);
   endtask : sc_channel_pair

   task summarize();
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end

   initial
   begin
      rst = 1'h1;
      vin_a = 12'h000;
      vin_b = 12'h000;
      repeat (10) @(posedge clk_sys);
      #1 rst = 1'h0;
      repeat (3) @(posedge clk_sys);
      sc_coding_table();
      sc_abort();
      sc_channel_pair();
      summarize();
   end
endmodule : testbench
